// *** include/adcpc_defines.svh ***
// Timing, width and reset constants of the converter control block.
// Assumes a 40 MHz mclk; included by the design modules and the test modules.
`ifndef ADCPC_DEFINES_SVH
`define ADCPC_DEFINES_SVH

// Clock and conversion timing, in nanoseconds as given.
`define ADCPC_MCLK_NS         25
`define ADCPC_INT_PERIOD_NS   67
`define ADCPC_INT_MAX_NS      900
`define ADCPC_INT_DIV_CYC     (`ADCPC_INT_PERIOD_NS / `ADCPC_MCLK_NS)
`define ADCPC_INT_MAX_CYC     (`ADCPC_INT_MAX_NS / `ADCPC_MCLK_NS)
`define ADCPC_CONV_TICKS      13

// Widths and reset values.
`define ADCPC_RESULT_W        12
`define ADCPC_CNT_W           4
`define ADCPC_RESULT_RST      12'h000
`define ADCPC_BUF_DEPTH       2

// Bit positions inside the pin synchroniser vector.
`define ADCPC_SI_START        0
`define ADCPC_SI_PD           1
`define ADCPC_SI_ECLK         2
`define ADCPC_SI_MODE         3
`define ADCPC_SI_CS           4
`define ADCPC_SI_RD           5
`define ADCPC_SI_N            6
// Idle levels of the synchronised pins: select and read strobe high, the rest low.
`define ADCPC_SI_RST          6'h30

`endif

// *** include/adcpc_pkg.sv ***
// Types shared by the converter control block.
// Assumes nothing beyond the defines header.
package adcpc_pkg;

    // Conversion sequencer states; code 2'b11 is unused.
    typedef enum logic [1:0] {
        ST_TRACK = 2'b00,
        ST_CONV  = 2'b01,
        ST_PUSH  = 2'b10
    } adcpc_state_t;

endpackage : adcpc_pkg

// *** verilog/adcpc_buf2.sv ***
// Small valid/ready buffer between the converter and the output latch.
// Assumes one clock, synchronous active-high reset and a clock enable.
`include "adcpc_defines.svh"
module adcpc_buf2 #(
    parameter int W     = `ADCPC_RESULT_W,
    parameter int DEPTH = `ADCPC_BUF_DEPTH
) (
    // Clock, reset, enable.
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         ce,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import adcpc_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   count_ff;
    logic          push;
    logic          pop;

    // Advances a pointer and wraps it at the buffer depth.
    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : next_ptr

    // Honest full and empty flags straight from the occupancy count.
    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write.
    always_ff @(posedge mclk) begin
        if (ce && push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_ff <= next_ptr(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= next_ptr(rd_ptr_ff);
            end
            count_ff <= (AW+1)'(count_ff + (AW+1)'(push) - (AW+1)'(pop));
        end
    end

endmodule : adcpc_buf2

// *** verilog/adcpc_top.sv ***
// Digital control and readout of a single-channel 12-bit sampling converter.
// Assumes pins arrive asynchronously to mclk (40 MHz) and the converted code on adc_code is mclk-synchronous.
//
// Contract
// RQ1: Result is a 12-bit word, driven only while read strobe and select are low.
// RQ2: Chip select low enables the interface; high floats all twelve outputs.
// RQ3: Host pulls read strobe low; device then presents the latched result.
// RQ4: Completion flag falls at completion, rises at next conversion-clock edge or start fall; in internal mode the code raises it at the second tick.
// RQ5: Last-done flag falls at final completion, stays low until start falls.
// RQ6: A rising start edge begins the conversion.
// RQ7: Sample taken at start rise; track while start low, hold while high.
// RQ8: Host keeps start low at least 100 ns before raising it.
// RQ9: Host keeps the acquisition interval no longer than 1 ms.
// RQ10: Clock-source strap high picks internal oscillator, low the external clock.
// RQ11: Host gives external clock of 100 kHz to 20 MHz, else ties it low.
// RQ12: Power-down high puts the device in shutdown; low is normal operation.
// RQ13: Write strobe and channel power-down inputs have no effect.
// RQ14: Device sustains 1075 ksps with result ready 0.72 us after sampling.
// RQ15: A conversion takes exactly thirteen conversion-clock periods.
// RQ16: Start falling mid-conversion aborts it and begins a new acquisition.
// RQ17: In internal mode flags fall within 900 ns of start rising.
// RQ18: A falling power-down edge starts a conversion like a start rise.
// RQ19: The latest result stays stable until the next conversion overwrites it.
`include "adcpc_defines.svh"
module adcpc_top #(
    parameter int RESULT_W   = `ADCPC_RESULT_W,
    parameter int CONV_TICKS = `ADCPC_CONV_TICKS
) (
    // Clock, reset, enable.
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    // Converter pins from the host.
    input  wire logic                  sample_start,
    input  wire logic                  power_down,
    input  wire logic                  clock_source_select,
    input  wire logic                  ext_clk,
    input  wire logic                  cs_n,
    input  wire logic                  rd_n,
    input  wire logic                  wr_unused_n,
    input  wire logic                  channel_power_down_unused,
    // Code from the comparator array.
    input  wire logic [RESULT_W-1:0]   adc_code,
    // Result bus, split into level and enable.
    output logic [RESULT_W-1:0]        result_bus,
    output logic                       result_bus_oe,
    // Status pins.
    output logic                       conv_done_flag_n,
    output logic                       last_done_flag_n,
    output logic                       track_hold,
    output logic                       shutdown_active,
    output adcpc_pkg::adcpc_state_t    conv_state
);
    import adcpc_pkg::*;

    localparam int CW      = `ADCPC_CNT_W;
    localparam int DIV_CYC = `ADCPC_INT_DIV_CYC;
    localparam int INT_MAX = `ADCPC_INT_MAX_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.

    logic [`ADCPC_SI_N-1:0] sync1_ff;
    logic [`ADCPC_SI_N-1:0] sync2_ff;
    logic [`ADCPC_SI_N-1:0] prev_ff;

    // Detects a rising edge between two samples.
    function automatic logic rise(input logic cur, input logic prv);
        return cur & ~prv;
    endfunction : rise

    // Every pin that is read passes two flops; logic reads the second stage, and edge detection also reads a third stage.
    // Reset loads the idle pin levels, so no read or edge is seen after reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_ff <= `ADCPC_SI_RST; // [RQ2]
            sync2_ff <= `ADCPC_SI_RST;
            prev_ff  <= `ADCPC_SI_RST;
        end else if (ce) begin
            sync1_ff <= {rd_n, cs_n, clock_source_select, ext_clk, power_down, sample_start};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    logic start_s, pd_s, int_mode, reading;
    logic start_rise, start_fall, pd_fall, eclk_rise;
    assign start_s    = sync2_ff[`ADCPC_SI_START];
    assign pd_s       = sync2_ff[`ADCPC_SI_PD];
    assign int_mode   = sync2_ff[`ADCPC_SI_MODE]; // [RQ10]
    assign reading    = !sync2_ff[`ADCPC_SI_CS] && !sync2_ff[`ADCPC_SI_RD]; // [RQ3]
    assign start_rise = rise(start_s, prev_ff[`ADCPC_SI_START]);
    assign start_fall = rise(prev_ff[`ADCPC_SI_START], start_s);
    assign pd_fall    = rise(prev_ff[`ADCPC_SI_PD], pd_s);
    assign eclk_rise  = rise(sync2_ff[`ADCPC_SI_ECLK], prev_ff[`ADCPC_SI_ECLK]);
    // The write strobe and channel power-down pins are deliberately left unread. [RQ13]

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock: internal divider or external clock edges.

    logic [CW-1:0] div_ff;
    logic          conv_tick;

    // Internal oscillator stand-in; its period keeps 13 ticks well under 0.72 us. [RQ14]
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_ff <= '0;
        end else if (ce) begin
            div_ff <= (div_ff == CW'(DIV_CYC - 1)) ? '0 : CW'(div_ff + 1'b1);
        end
    end

    assign conv_tick = int_mode ? (div_ff == CW'(DIV_CYC - 1)) : eclk_rise; // [RQ10]

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer and track-and-hold.

    adcpc_state_t        st_ff;
    logic [CW-1:0]       tick_cnt_ff;
    logic [RESULT_W-1:0] held_ff;
    logic                go;
    logic                buf_in_ready;
    logic                buf_out_valid;
    logic [RESULT_W-1:0] buf_out_data;
    logic                out_load;

    // Start on a rising start edge or on leaving shutdown. [RQ6] [RQ18]
    assign go = (st_ff == ST_TRACK) && ((start_rise && !pd_s) || pd_fall);

    // Sequencer: abort on start fall, finish after exactly the tick count.
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff       <= ST_TRACK;
            tick_cnt_ff <= '0;
        end else if (ce) begin
            unique case (st_ff)
                ST_TRACK: begin
                    tick_cnt_ff <= '0;
                    if (go) begin
                        st_ff <= ST_CONV; // [RQ6]
                    end
                end
                ST_CONV: begin
                    if (pd_s || start_fall) begin
                        st_ff <= ST_TRACK; // [RQ16] [RQ12]
                    end else if (conv_tick) begin
                        if (tick_cnt_ff == CW'(CONV_TICKS - 1)) begin
                            st_ff <= ST_PUSH; // [RQ15]
                        end else begin
                            tick_cnt_ff <= CW'(tick_cnt_ff + 1'b1);
                        end
                    end
                end
                ST_PUSH: begin
                    // Waits here while the buffer is full.
                    if (pd_s || buf_in_ready) begin
                        st_ff <= ST_TRACK;
                    end
                end
                default: begin
                    st_ff <= ST_TRACK;
                end
            endcase
        end
    end

    // Sampling instant captures the code; hold level follows the start pin. [RQ7]
    always_ff @(posedge mclk) begin
        if (srst) begin
            held_ff    <= `ADCPC_RESULT_RST;
            track_hold <= 1'b0;
        end else if (ce) begin
            track_hold <= start_s;
            if (go) begin
                held_ff <= adc_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result buffer and output latch.

    adcpc_buf2 #(
        .W     (RESULT_W),
        .DEPTH (`ADCPC_BUF_DEPTH)
    ) u_buf (
        .mclk      (mclk),
        .srst      (srst),
        .ce        (ce),
        .in_valid  ((st_ff == ST_PUSH) && !pd_s),
        .in_ready  (buf_in_ready),
        .in_data   (held_ff),
        .out_valid (buf_out_valid),
        .out_ready (!reading),
        .out_data  (buf_out_data)
    );

    // A new result never replaces the latch while the host reads it. [RQ19]
    assign out_load = buf_out_valid && !reading;

    // Output latch and bus enable from the synchronised strobes. [RQ1] [RQ2]
    always_ff @(posedge mclk) begin
        if (srst) begin
            result_bus    <= `ADCPC_RESULT_RST;
            result_bus_oe <= 1'b0;
        end else if (ce) begin
            result_bus_oe <= reading; // [RQ1] [RQ2] [RQ3]
            if (out_load) begin
                result_bus <= buf_out_data; // [RQ19]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion flags and shutdown status.

    logic eoc_armed_ff;

    // Completion flag: set wins over clear; internal mode waits one full tick.
    always_ff @(posedge mclk) begin
        if (srst) begin
            conv_done_flag_n <= 1'b1;
            eoc_armed_ff     <= 1'b0;
        end else if (ce) begin
            if (pd_s) begin
                conv_done_flag_n <= 1'b1; // [RQ12]
                eoc_armed_ff     <= 1'b0;
            end else if (out_load) begin
                conv_done_flag_n <= 1'b0; // [RQ4] [RQ17]
                eoc_armed_ff     <= !int_mode;
            end else if (start_fall || (conv_tick && eoc_armed_ff)) begin
                conv_done_flag_n <= 1'b1; // [RQ4]
            end else if (conv_tick) begin
                eoc_armed_ff <= 1'b1;
            end
        end
    end

    // Every conversion ends a one-conversion sequence. [RQ5]
    always_ff @(posedge mclk) begin
        if (srst) begin
            last_done_flag_n <= 1'b1;
            shutdown_active  <= 1'b0;
            conv_state       <= ST_TRACK;
        end else if (ce) begin
            shutdown_active <= pd_s; // [RQ12]
            conv_state      <= st_ff;
            if (pd_s) begin
                last_done_flag_n <= 1'b1;
            end else if (out_load) begin
                last_done_flag_n <= 1'b0; // [RQ5]
            end else if (start_fall) begin
                last_done_flag_n <= 1'b1; // [RQ5]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !ce);

    sequence s_int_start;
        go && int_mode && !pd_s && ce;
    endsequence
    sequence s_flag_or_out;
        !conv_done_flag_n || !start_s || pd_s || !buf_in_ready || reading;
    endsequence

    AST_BUS_WHEN_READ: assert property (result_bus_oe |-> $past(reading)) // [RQ1]
        else $error("Result bus driven without read and select.");
    AST_CS_FLOATS: assert property ($past(sync2_ff[`ADCPC_SI_CS]) |-> !result_bus_oe) // [RQ2]
        else $error("Result bus driven while deselected.");
    AST_EOC_FALL: assert property (out_load && !pd_s |=> !conv_done_flag_n && !last_done_flag_n) // [RQ4]
        else $error("Completion flags did not fall with new result.");
    AST_EOC_RISE: assert property (!conv_done_flag_n && start_fall && !out_load |=> conv_done_flag_n) // [RQ4]
        else $error("Completion flag did not return high on start fall.");
    AST_LAST_DONE_FLAG_N_HOLD: assert property (!last_done_flag_n && !start_fall && !pd_s |=> !last_done_flag_n) // [RQ5]
        else $error("Last-done flag rose early.");
    AST_START_RISE: assert property (st_ff == ST_TRACK && start_rise && !pd_s |=> st_ff == ST_CONV) // [RQ6]
        else $error("Start edge did not begin a conversion.");
    AST_HOLD_LEVEL: assert property (start_s |=> track_hold) // [RQ7]
        else $error("Hold level not following start pin.");
    AST_SHUTDOWN: assert property (pd_s |=> conv_done_flag_n && last_done_flag_n && shutdown_active) // [RQ12]
        else $error("Flags not high in shutdown.");
    AST_ABORT: assert property (st_ff == ST_CONV && start_fall |=> st_ff == ST_TRACK) // [RQ16]
        else $error("Conversion not aborted on start fall.");
    AST_LAST_TICK: assert property (st_ff == ST_CONV && conv_tick && !start_fall && !pd_s
        && tick_cnt_ff == CW'(CONV_TICKS - 1) |=> st_ff == ST_PUSH) // [RQ15]
        else $error("Conversion length not thirteen ticks.");
    AST_INT_LATENCY: assert property (s_int_start |-> ##[1:INT_MAX] s_flag_or_out) // [RQ17]
        else $error("Internal conversion exceeded its limit.");
    AST_PD_EXIT: assert property (st_ff == ST_TRACK && pd_fall |=> st_ff == ST_CONV) // [RQ18]
        else $error("Leaving shutdown did not start a conversion.");
    AST_STABLE: assert property (!out_load |=> $stable(result_bus)) // [RQ19]
        else $error("Result changed without a new conversion.");

endmodule : adcpc_top

// *** test/adcpc_host_model.sv ***
// Host-side model: drives the start, read strobe, select and external clock pins.
// Assumes the bench calls its tasks from one process that runs on mclk.
`include "adcpc_defines.svh"
module adcpc_host_model (
    // Clock.
    input  wire logic mclk,
    // Pins towards the converter.
    output logic      sample_start,
    output logic      ext_clk,
    output logic      cs_n,
    output logic      rd_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       ext_run = 1'b0;
    logic [2:0] ext_cnt = 3'h0;

    // Idle levels: start low (tracking), bus deselected, clock still.
    initial begin
        sample_start = 1'b0;
        cs_n         = 1'b1;
        rd_n         = 1'b1;
        ext_clk      = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock of 8 mclk periods (5 MHz); it stands low outside frames.
    always @(posedge mclk) begin
        if (ext_run) begin
            ext_cnt <= ext_cnt + 3'h1;
            ext_clk <= ext_cnt[2];
        end else begin
            ext_cnt <= 3'h0;
            ext_clk <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acquisition phase of acq cycles (at least 4, so 100 ns), then the start rise.
    task automatic start_conv(input int acq);
        @(posedge mclk);
        sample_start <= 1'b0;
        repeat (acq) @(posedge mclk);
        sample_start <= 1'b1;
    endtask : start_conv

    // Pulls start low in the middle of a conversion.
    task automatic drop_start();
        @(posedge mclk);
        sample_start <= 1'b0;
    endtask : drop_start

    // Sets select and read strobe; both low asks for the result.
    task automatic set_bus(input logic cs, input logic rd);
        @(posedge mclk);
        cs_n <= cs;
        rd_n <= rd;
    endtask : set_bus

    // Starts or stops the external conversion clock.
    task automatic set_ext(input logic on);
        @(posedge mclk);
        ext_run <= on;
    endtask : set_ext

endmodule : adcpc_host_model

// *** test/adcpc_top_tb.sv ***
// Self-checking bench of the converter control block.
// Assumes the host model drives start, bus and clock pins; the bench drives the rest.
`include "adcpc_defines.svh"
module adcpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcpc_pkg::*;

    logic                       mclk = 1'b0;
    logic                       srst = 1'b1;
    logic                       ce = 1'b1;
    logic                       power_down = 1'b0;
    logic                       clock_source_select = 1'b1;
    logic                       wr_unused_n = 1'b1;
    logic                       channel_power_down_unused = 1'b0;
    logic [`ADCPC_RESULT_W-1:0] adc_code = 12'h000;
    logic                       sample_start, ext_clk, cs_n, rd_n;
    logic [`ADCPC_RESULT_W-1:0] result_bus;
    logic                       result_bus_oe, conv_done_flag_n, last_done_flag_n;
    logic                       track_hold, shutdown_active;
    adcpc_state_t               conv_state;
    logic [`ADCPC_RESULT_W-1:0] codes [3];
    logic [`ADCPC_RESULT_W-1:0] held_code;
    int                         mismatches = 0;
    int                         num_checks = 0;
    int                         ext_rises = 0;
    int                         n;

    adcpc_top #(.RESULT_W(`ADCPC_RESULT_W), .CONV_TICKS(`ADCPC_CONV_TICKS)) i_adcpc_top (
        .mclk(mclk), .srst(srst), .ce(ce), .sample_start(sample_start), .power_down(power_down),
        .clock_source_select(clock_source_select), .ext_clk(ext_clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_unused_n(wr_unused_n), .channel_power_down_unused(channel_power_down_unused),
        .adc_code(adc_code), .result_bus(result_bus), .result_bus_oe(result_bus_oe),
        .conv_done_flag_n(conv_done_flag_n), .last_done_flag_n(last_done_flag_n),
        .track_hold(track_hold), .shutdown_active(shutdown_active), .conv_state(conv_state));

    adcpc_host_model i_adcpc_host_model (
        .mclk(mclk), .sample_start(sample_start), .ext_clk(ext_clk), .cs_n(cs_n), .rd_n(rd_n));

    // 40 MHz clock and a count of external clock rises.
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge ext_clk) ext_rises <= ext_rises + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Expected bus enable for one select and strobe setting.
    function automatic logic [15:0] exp_oe(input logic cs, input logic rd);
        return {15'h0000, ~cs & ~rd};
    endfunction : exp_oe

    // One when a latency in cycles lies within its limit.
    function automatic logic [15:0] lat_ok(input int cyc, input int lim);
        return (cyc <= lim) ? 16'h0001 : 16'h0000;
    endfunction : lat_ok

    // Compares one value with its expectation.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waits, with a bound, until the last-done flag falls; cyc counts edges.
    task automatic wait_done(output int cyc);
        cyc = 0;
        do begin
            @(posedge mclk);
            #1;
            cyc++;
        end while (last_done_flag_n !== 1'b0 && cyc < 160);
    endtask : wait_done

    // Loads a code and runs one conversion started by the start pin.
    task automatic conv(input logic [11:0] code, output int cyc);
        @(posedge mclk);
        adc_code <= code;
        i_adcpc_host_model.start_conv(4 + $urandom_range(16));
        wait_done(cyc);
    endtask : conv

    // Walks select and strobe through all four settings, ending in a read.
    task automatic read_all(input logic [11:0] code);
        for (int i = 3; i >= 0; i--) begin
            i_adcpc_host_model.set_bus(i[1], i[0]);
            repeat (5) @(posedge mclk);
            #1;
            check(result_bus_oe, exp_oe(i[1], i[0]));
        end
        check(result_bus, code);
        i_adcpc_host_model.set_bus(1'b1, 1'b1);
    endtask : read_all

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: far beyond the one to two thousand cycles the tests take.
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence of tests.
    initial begin
        void'($urandom(5546));
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        check({result_bus_oe, conv_done_flag_n, last_done_flag_n, track_hold, shutdown_active, conv_state},
              16'h0030);
        check(result_bus, 16'h0000);
        $display("test reset done");

        // Internal clock conversions, corner codes first; unused pins toggle.
        for (int k = 0; k < 6; k++) begin
            codes[0] = (k == 0) ? 12'hFFF : (k == 1) ? 12'h000 : 12'($urandom);
            wr_unused_n <= 1'($urandom);
            channel_power_down_unused <= 1'($urandom);
            conv(codes[0], n);
            check(lat_ok(n, `ADCPC_INT_MAX_CYC), 16'h0001);
            check(conv_done_flag_n, 16'h0000);
            check(track_hold, 16'h0001);
            read_all(codes[0]);
            check(last_done_flag_n, 16'h0000);
        end
        i_adcpc_host_model.drop_start();
        repeat (5) @(posedge mclk);
        #1;
        check({conv_done_flag_n, last_done_flag_n, track_hold}, 16'h0006);
        $display("test internal done");

        // Start falls mid-conversion: no result, then a fresh conversion.
        @(posedge mclk);
        adc_code <= 12'h5A3;
        i_adcpc_host_model.start_conv(8);
        repeat (10) @(posedge mclk);
        i_adcpc_host_model.drop_start();
        repeat (40) @(posedge mclk);
        #1;
        check({conv_state, last_done_flag_n}, {13'h0000, ST_TRACK, 1'b1});
        conv(12'hA5C, n);
        read_all(12'hA5C);
        $display("test abort done");

        // External clock: flags after exactly the 13th rise, done flag back at the next.
        clock_source_select <= 1'b0;
        codes[0] = 12'($urandom);
        @(posedge mclk);
        adc_code <= codes[0];
        i_adcpc_host_model.start_conv(6);
        repeat (4) @(posedge mclk);
        ext_rises = 0;
        i_adcpc_host_model.set_ext(1'b1);
        wait_done(n);
        check(16'(ext_rises), 16'(`ADCPC_CONV_TICKS));
        n = 0;
        while (conv_done_flag_n !== 1'b1 && n < 16) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(16'(ext_rises), 16'(`ADCPC_CONV_TICKS + 1));
        check(last_done_flag_n, 16'h0000);
        i_adcpc_host_model.set_ext(1'b0);
        read_all(codes[0]);
        $display("test external done");

        // Shutdown raises the flags; leaving it starts a conversion.
        power_down <= 1'b1;
        clock_source_select <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        check({shutdown_active, conv_done_flag_n, last_done_flag_n}, 16'h0007);
        codes[0] = 12'($urandom);
        @(posedge mclk);
        adc_code <= codes[0];
        power_down <= 1'b0;
        wait_done(n);
        check(lat_ok(n, `ADCPC_INT_MAX_CYC), 16'h0001);
        read_all(codes[0]);
        $display("test shutdown done");

        // A held read fills the buffer until the sequencer waits; release drains it.
        held_code = codes[0];
        i_adcpc_host_model.set_bus(1'b0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            codes[k] = 12'($urandom);
            conv(codes[k], n);
        end
        check(conv_state, {14'h0000, ST_PUSH});
        check(result_bus, held_code);
        check(result_bus_oe, 16'h0001);
        i_adcpc_host_model.set_bus(1'b1, 1'b1);
        repeat (12) @(posedge mclk);
        read_all(codes[2]);
        $display("test buffer done");
        final_report();
    end

endmodule : adcpc_top_tb
